// >>> logic/dhm_params.svh
// Constants for the deep halt mode controller: offsets, fields, counts.
// Assumes inclusion by the package and the bench only.
`ifndef DHM_PARAMS_SVH
`define DHM_PARAMS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define DHM_OFF_SYSCTL 5'h00
`define DHM_OFF_CLKCTL 5'h04
`define DHM_OFF_WUSET 5'h08
`define DHM_OFF_STAT 5'h0c
`define DHM_OFF_PC 5'h10
`define DHM_OFF_KEY 5'h14
// ==========================================================
// Field positions
`define DHM_B_HALT 7
`define DHM_B_RELEASE_MODE_SELECT 6
`define DHM_B_HOLD 4
`define DHM_B_WUSEL 0
`define DHM_B_SYSLOW 1
`define DHM_B_HFON 2
`define DHM_B_LFON 3
`define DHM_B_KEYEN 0
`define DHM_B_KEYLVL 1
// ==========================================================
// Reset values
`define DHM_RST_SYSCTL 8'h00
`define DHM_RST_CLKCTL 8'h04
`define DHM_RST_WUSET 8'h10
`define DHM_RST_KEY 8'h00
// ==========================================================
// Timing counts in mclk cycles, and the resume address step
`define DHM_MC_CLKS 3'h4
`define DHM_HF_DIV 8'h03
`define DHM_LF_DIV 8'h3f
`define DHM_PC_STEP 16'h0002
`endif

// >>> logic/dhm_pkg.sv
// Types shared by the deep halt mode controller.
// Assumes dhm_params.svh is on the include path.
`default_nettype none
package dhm_pkg;
	`include "dhm_params.svh"
	// Controller states
	typedef enum logic [1:0] {
		DHM_ST_RUN,
		DHM_ST_HALT,
		DHM_ST_WARM,
		DHM_ST_VRST
	} dhm_state_t;
endpackage
`default_nettype wire

// >>> logic/dhm_sync.sv
// Two-flop synchronisers for the wake pins, plus release edge detect.
// Assumes the inputs are asynchronous to mclk.
`default_nettype none
module dhm_sync
	import dhm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] async_in,
	output logic [2:0] sync_q,
	output logic rise_q
);
	logic [2:0] meta_q;
	logic [2:0] meta_d;
	logic [2:0] sync_d;
	logic last_q;
	logic last_d;
	logic rise_d;

	// ==========================================================
	// Next values
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
		last_d = sync_q[0];
		rise_d = sync_q[0] & ~last_q;
	end

	// Registers, first stage read only by the second
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
			last_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
			rise_q <= rise_d;
		end
	end
endmodule
`default_nettype wire

// >>> logic/dhm_ctrl.sv
// Deep halt mode controller with an Avalon-MM register slave.
// Assumes one 40 MHz mclk kept alive for wake detection, and a CPU
// that presents the halting instruction's address on halt_instr_addr.
//
// Behaviour
// - writing one to halt bit enters halt
// - halt stops both oscillators and core
// - state retained; port latches follow hold select
// - halt entry clears timing generator prescaler
// - resume address is halt instruction plus two
// - resets end halt, warm-up, then run
// - release by pin, key wakeup, voltage detect
// - release mode bit: one level, zero edge
// - level mode releases on high pin
// - level mode ignores request while pin high
// - pin low during warm-up never re-halts
// - warm-up source follows clock at entry
// - edge mode releases on rising pin edge
// - edge mode enters halt with pin high
// - edge within one machine cycle ignored
// - warm-up keeps core stopped, then resume
// - key wakeup releases at selected level
//
// Our own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
module dhm_ctrl
	import dhm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic shared_port_pin,
	input wire logic key_wake_pin,
	input wire logic vdet_low,
	input wire logic [15:0] halt_instr_addr,
	output logic hf_osc_en_q,
	output logic lf_osc_en_q,
	output logic core_run_q,
	output logic tg_clear_q,
	output logic port_float_q,
	output logic wu_src_low_q,
	output logic halted_q,
	output logic [15:0] resume_pc_q
);
	// ==========================================================
	// Synchronised wake inputs
	logic [2:0] wake_s;
	logic rel_rise;
	logic rel_s;
	logic key_s;
	logic vdet_s;

	dhm_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({vdet_low, key_wake_pin, shared_port_pin}),
		.sync_q(wake_s),
		.rise_q(rel_rise)
	);
	assign rel_s = wake_s[0];
	assign key_s = wake_s[1];
	assign vdet_s = wake_s[2];

	// ==========================================================
	// Functions
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a == o);
	endfunction

	function automatic logic [7:0] div_limit(input logic low);
		div_limit = low ? `DHM_LF_DIV : `DHM_HF_DIV;
	endfunction

	// ==========================================================
	// State
	dhm_state_t state_q, state_d;
	logic release_mode_select_q, release_mode_select_d;
	logic hold_q, hold_d;
	logic [3:0] clk_q, clk_d;
	logic [7:0] wuset_q, wuset_d;
	logic [1:0] key_q, key_d;
	logic [2:0] blank_q, blank_d;
	logic [7:0] div_q, div_d;
	logic [7:0] cnt_q, cnt_d;
	logic entry_low_q, entry_low_d;
	logic [31:0] rdata_d;
	logic wait_d;
	logic hf_d, lf_d, run_d, tgc_d, float_d, wsrc_d, halted_d;
	logic [15:0] pc_d;
	logic bus_wr, wr_sys, halt_req, key_hit, rel_ok, active;
	logic [7:0] wu_goal;

	// Write strobe at the completing edge, low byte lane
	assign bus_wr = write & ~waitrequest & byteenable[0];
	assign wr_sys = bus_wr & hit(address, `DHM_OFF_SYSCTL);
	assign halt_req = wr_sys & writedata[`DHM_B_HALT];
	assign key_hit = key_q[`DHM_B_KEYEN] & (key_s == key_q[`DHM_B_KEYLVL]);
	assign wu_goal = (wuset_q == 8'h00) ? 8'h01 : wuset_q;

	// ==========================================================
	// Bus slave and control registers
	always_comb
	begin
		release_mode_select_d = release_mode_select_q;
		hold_d = hold_q;
		clk_d = clk_q;
		wuset_d = wuset_q;
		key_d = key_q;
		rdata_d = readdata;
		wait_d = 1'b1;
		// One wait cycle, data loaded at the edge that drops waitrequest
		if ((read | write) & waitrequest)
		begin
			wait_d = 1'b0;
			rdata_d = 32'h0;
			if (hit(address, `DHM_OFF_SYSCTL))
			begin
				// halt bit is the halt state
				rdata_d[`DHM_B_HALT] = (state_q == DHM_ST_HALT);
				rdata_d[`DHM_B_RELEASE_MODE_SELECT] = release_mode_select_q;
				rdata_d[`DHM_B_HOLD] = hold_q;
			end
			else if (hit(address, `DHM_OFF_CLKCTL))
				rdata_d[3:0] = clk_q;
			else if (hit(address, `DHM_OFF_WUSET))
				rdata_d[7:0] = wuset_q;
			else if (hit(address, `DHM_OFF_STAT))
				rdata_d[4:0] = {vdet_s, rel_s, entry_low_q,
					state_q == DHM_ST_WARM, state_q == DHM_ST_HALT};
			else if (hit(address, `DHM_OFF_PC))
				rdata_d[15:0] = resume_pc_q;
			else if (hit(address, `DHM_OFF_KEY))
				rdata_d[1:0] = key_q;
		end
		if (wr_sys)
		begin
			release_mode_select_d = writedata[`DHM_B_RELEASE_MODE_SELECT];
			hold_d = writedata[`DHM_B_HOLD];
		end
		if (bus_wr & hit(address, `DHM_OFF_CLKCTL))
			clk_d = writedata[3:0];
		if (bus_wr & hit(address, `DHM_OFF_WUSET))
			wuset_d = writedata[7:0];
		if (bus_wr & hit(address, `DHM_OFF_KEY))
			key_d = writedata[1:0];
		if (vdet_s)
		begin
			release_mode_select_d = 1'(`DHM_RST_SYSCTL >> `DHM_B_RELEASE_MODE_SELECT);
			hold_d = 1'(`DHM_RST_SYSCTL >> `DHM_B_HOLD);
			clk_d = 4'(`DHM_RST_CLKCTL);
			wuset_d = `DHM_RST_WUSET;
			key_d = 2'(`DHM_RST_KEY);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			release_mode_select_q <= 1'(`DHM_RST_SYSCTL >> `DHM_B_RELEASE_MODE_SELECT);
			hold_q <= 1'(`DHM_RST_SYSCTL >> `DHM_B_HOLD);
			clk_q <= 4'(`DHM_RST_CLKCTL);
			wuset_q <= `DHM_RST_WUSET;
			key_q <= 2'(`DHM_RST_KEY);
			readdata <= 32'h0;
			waitrequest <= 1'b1;
		end
		else
		begin
			release_mode_select_q <= release_mode_select_d;
			hold_q <= hold_d;
			clk_q <= clk_d;
			wuset_q <= wuset_d;
			key_q <= key_d;
			readdata <= rdata_d;
			waitrequest <= wait_d;
		end
	end

	// ==========================================================
	// Mode sequencer
	always_comb
	begin
		state_d = state_q;
		blank_d = blank_q;
		div_d = div_q;
		cnt_d = cnt_q;
		entry_low_d = entry_low_q;
		pc_d = resume_pc_q;
		tgc_d = 1'b0;
		rel_ok = 1'b0;
		case (state_q)
			DHM_ST_RUN:
			begin
				// level mode refuses while pin high
				// edge mode enters regardless of pin
				if (halt_req & ~(release_mode_select_q & rel_s))
				begin
					state_d = DHM_ST_HALT;
					blank_d = `DHM_MC_CLKS;
					entry_low_d = clk_q[`DHM_B_SYSLOW];
					pc_d = halt_instr_addr + `DHM_PC_STEP;
					tgc_d = 1'b1;
				end
			end
			DHM_ST_HALT:
			begin
				if (blank_q != 3'h0)
					blank_d = blank_q - 3'h1;
				// edges in the first machine cycle lost
				rel_ok = release_mode_select_q ? rel_s : (rel_rise & (blank_q == 3'h0));
				if (rel_ok | key_hit)
				begin
					state_d = DHM_ST_WARM;
					div_d = 8'h00;
					cnt_d = 8'h00;
				end
			end
			DHM_ST_WARM:
			begin
				if (div_q == div_limit(entry_low_q))
				begin
					div_d = 8'h00;
					cnt_d = cnt_q + 8'h01;
				end
				else
					div_d = div_q + 8'h01;
				if (cnt_q >= wu_goal)
				begin
					state_d = DHM_ST_RUN;
					tgc_d = 1'b1;
				end
			end
			DHM_ST_VRST:
			begin
				if (!vdet_s)
				begin
					state_d = DHM_ST_WARM;
					div_d = 8'h00;
					cnt_d = 8'h00;
					entry_low_d = 1'b0;
				end
			end
			default:
				state_d = DHM_ST_RUN;
		endcase
		if (vdet_s)
		begin
			state_d = DHM_ST_VRST;
			entry_low_d = 1'b0;
		end
		active = (state_d == DHM_ST_RUN) | (state_d == DHM_ST_WARM);
		// oscillators and core stopped in halt
		hf_d = active & clk_d[`DHM_B_HFON];
		lf_d = active & clk_d[`DHM_B_LFON];
		run_d = (state_d == DHM_ST_RUN);
		halted_d = (state_d == DHM_ST_HALT);
		float_d = ~run_d & ~hold_d;
		// warm-up source is the entry clock
		wsrc_d = (state_d == DHM_ST_WARM) ? entry_low_d
			: clk_d[`DHM_B_WUSEL];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// power-on and pin reset start in warm-up
			state_q <= DHM_ST_WARM;
			blank_q <= 3'h0;
			div_q <= 8'h00;
			cnt_q <= 8'h00;
			entry_low_q <= 1'b0;
			resume_pc_q <= 16'h0000;
			hf_osc_en_q <= 1'b1;
			lf_osc_en_q <= 1'b0;
			core_run_q <= 1'b0;
			tg_clear_q <= 1'b1;
			port_float_q <= 1'b1;
			wu_src_low_q <= 1'b0;
			halted_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			blank_q <= blank_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
			entry_low_q <= entry_low_d;
			resume_pc_q <= pc_d;
			hf_osc_en_q <= hf_d;
			lf_osc_en_q <= lf_d;
			core_run_q <= run_d;
			tg_clear_q <= tgc_d;
			port_float_q <= float_d;
			wu_src_low_q <= wsrc_d;
			halted_q <= halted_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	enter_halt_a: assert property (
		(state_q == DHM_ST_RUN) && halt_req && !release_mode_select_q && !vdet_s
		|=> halted_q && !core_run_q)
		else $error("halt request did not enter halt");
	osc_stop_a: assert property (
		halted_q |-> !hf_osc_en_q && !lf_osc_en_q && !core_run_q)
		else $error("oscillator or core running in halt");
	port_hold_a: assert property (
		halted_q && hold_q |-> !port_float_q)
		else $error("ports float despite hold select");
	tg_clear_a: assert property (
		$rose(halted_q) |-> tg_clear_q)
		else $error("timing generator not cleared at entry");
	resume_pc_a: assert property (
		$rose(halted_q) |->
		resume_pc_q == $past(halt_instr_addr) + `DHM_PC_STEP)
		else $error("resume address wrong");
	level_refuse_a: assert property (
		(state_q == DHM_ST_RUN) && halt_req && release_mode_select_q && rel_s
		&& !vdet_s |=> (state_q == DHM_ST_RUN) [*2])
		else $error("level mode halted with pin high");
	edge_blank_a: assert property (
		(state_q == DHM_ST_HALT) && !release_mode_select_q && !key_hit && !vdet_s
		&& (blank_q != 3'h0) |=> state_q == DHM_ST_HALT)
		else $error("edge released inside first machine cycle");
	edge_release_a: assert property (
		(state_q == DHM_ST_HALT) && !release_mode_select_q && rel_rise && !vdet_s
		&& (blank_q == 3'h0) |=> !halted_q)
		else $error("rising edge did not release");
	warm_stay_a: assert property (
		(state_q == DHM_ST_WARM) && !vdet_s |=>
		state_q inside {DHM_ST_WARM, DHM_ST_RUN, DHM_ST_VRST})
		else $error("warm-up returned to halt");
	warm_source_a: assert property (
		(state_q == DHM_ST_WARM) |-> ##1
		(state_q != DHM_ST_WARM) || (wu_src_low_q == entry_low_q))
		else $error("warm-up source not entry clock");
	bus_answer_a: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");

	halt_entry_c: cover property ($rose(halted_q));
	level_rel_c: cover property (
		(state_q == DHM_ST_HALT) && release_mode_select_q && rel_s);
	edge_rel_c: cover property (
		(state_q == DHM_ST_HALT) && !release_mode_select_q && rel_rise);
	key_rel_c: cover property ((state_q == DHM_ST_HALT) && key_hit);
endmodule
`default_nettype wire

// >>> verification/dhm_wake_src.sv
// Wake source model: drives the release pin and the key wakeup input.
// Assumes the bench sets wanted levels and a lag in mclk cycles.
`default_nettype none
module dhm_wake_src
(
	input wire logic mclk,
	input wire logic want_pin,
	input wire logic want_key,
	input wire logic [3:0] lag,
	output logic shared_port_pin,
	output logic key_wake_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic pin_q;
	initial
	begin
		cnt_q = 4'h0;
		pin_q = 1'b0;
	end
	// pin settles only after the lag
	always @(posedge mclk)
	begin
		if (want_pin == pin_q)
			cnt_q <= 4'h0;
		else if (cnt_q >= lag)
		begin
			pin_q <= want_pin;
			cnt_q <= 4'h0;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
	// Zero lag answers at once, else the slow path
	assign shared_port_pin = (lag == 4'h0) ? want_pin : pin_q;
	assign key_wake_pin = want_key;
endmodule
`default_nettype wire

// >>> verification/tb_dhm_ctrl.sv
// Bench for the deep halt controller: bus tasks and halt sequences.
// Assumes dhm_ctrl and the wake source model are compiled first.
`include "dhm_params.svh"
`default_nettype none
module tb_dhm_ctrl;
	import dhm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, read, write, vdet_low, want_pin, want_key;
	logic [4:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0] byteenable, lag;
	logic waitrequest, shared_port_pin, key_wake_pin;
	logic [15:0] halt_instr_addr, resume_pc_q;
	logic hf_osc_en_q, lf_osc_en_q, core_run_q, tg_clear_q;
	logic port_float_q, wu_src_low_q, halted_q;
	int n_mismatch, checks_done, n_tgc, k;
	logic [7:0] cv[2];
	logic ev[2];
	dhm_ctrl dhm_ctrl_i (.mclk, .rst_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest,
		.shared_port_pin, .key_wake_pin, .vdet_low, .halt_instr_addr,
		.hf_osc_en_q, .lf_osc_en_q, .core_run_q, .tg_clear_q,
		.port_float_q, .wu_src_low_q, .halted_q, .resume_pc_q);
	dhm_wake_src dhm_wake_src_i (.mclk, .want_pin, .want_key, .lag,
		.shared_port_pin, .key_wake_pin);
	// ==========================================================
	// Clock and pulse counter
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (tg_clear_q === 1'b1)
			n_tgc++;
	// ==========================================================
	// Report, compare and bus tasks
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Request held until waitrequest sampled low
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int i;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		read <= ~w;
		write <= w;
		for (i = 0; i < 100; i++)
		begin
			@(posedge mclk);
			if (waitrequest === 1'b0)
				break;
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 100)
		begin
			chk(32'h0, 32'h1);
			give_verdict();
		end
		@(posedge mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 4'hf);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 4'hf);
		chk(rd, {24'h0, e});
	endtask
	// Bounded wait: h selects halted_q, else core_run_q
	task automatic wfor(input logic h, input logic v);
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge mclk);
			if ((h ? halted_q : core_run_q) === v)
				break;
		end
		if (i == 3000)
		begin
			chk(32'h0, 32'h1);
			give_verdict();
		end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'h0;
		vdet_low = 1'b0;
		want_pin = 1'b0;
		want_key = 1'b0;
		lag = 4'h0;
		halt_instr_addr = 16'h1234;
		cv = '{8'h0e, 8'h05};
		ev = '{1'b1, 1'b0};
		wt(10);
		rst_n <= 1'b1;
		wfor(1'b0, 1'b1);
		rdc(`DHM_OFF_SYSCTL, 8'h00);
		rdc(`DHM_OFF_CLKCTL, 8'h04);
		rdc(`DHM_OFF_WUSET, 8'h10);
		rdc(`DHM_OFF_KEY, 8'h00);
		rdc(5'h18, 8'h00);
		chb(lf_osc_en_q, 1'b0);
		acc(1'b1, `DHM_OFF_WUSET, 8'h02, 4'h0);
		rdc(`DHM_OFF_WUSET, 8'h10);
		wr(`DHM_OFF_WUSET, 8'h02);
		// Edge mode, pin already high at entry
		want_pin <= 1'b1;
		wt(6);
		n_tgc = 0;
		wr(`DHM_OFF_SYSCTL, 8'h80);
		wt(2);
		chb(halted_q, 1'b1);
		chb(hf_osc_en_q | lf_osc_en_q | core_run_q, 1'b0);
		chk({16'h0, resume_pc_q}, 32'h1236);
		chk(n_tgc, 32'h1);
		chb(port_float_q, 1'b1);
		rdc(`DHM_OFF_SYSCTL, 8'h80);
		rdc(`DHM_OFF_STAT, 8'h09);
		acc(1'b0, `DHM_OFF_PC, 8'h00, 4'hf);
		chk(rd, 32'h1236);
		want_pin <= 1'b0;
		wt(8);
		want_pin <= 1'b1;
		wfor(1'b1, 1'b0);
		chb(core_run_q, 1'b0);
		wfor(1'b0, 1'b1);
		chb(hf_osc_en_q, 1'b1);
		rdc(`DHM_OFF_SYSCTL, 8'h00);
		// Edge inside the first machine cycle is lost
		want_pin <= 1'b0;
		halt_instr_addr <= 16'hfffe;
		wt(6);
		want_pin <= 1'b1;
		wr(`DHM_OFF_SYSCTL, 8'h80);
		wt(20);
		chb(halted_q, 1'b1);
		chk({16'h0, resume_pc_q}, 32'h0);
		want_pin <= 1'b0;
		wt(6);
		want_pin <= 1'b1;
		wfor(1'b1, 1'b0);
		wfor(1'b0, 1'b1);
		// Level mode refuses while pin high
		wr(`DHM_OFF_SYSCTL, 8'h40);
		wr(`DHM_OFF_SYSCTL, 8'hc0);
		wt(4);
		chb(halted_q, 1'b0);
		rdc(`DHM_OFF_SYSCTL, 8'h40);
		want_pin <= 1'b0;
		wt(6);
		wr(`DHM_OFF_SYSCTL, 8'hd0);
		wt(2);
		chb(halted_q, 1'b1);
		chb(port_float_q, 1'b0);
		lag <= 4'h5;
		want_pin <= 1'b1;
		wfor(1'b1, 1'b0);
		lag <= 4'h0;
		want_pin <= 1'b0;
		wfor(1'b0, 1'b1);
		chb(halted_q, 1'b0);
		// Warm-up source follows system clock at entry
		wr(`DHM_OFF_SYSCTL, 8'h00);
		for (k = 0; k < 2; k++)
		begin
			wr(`DHM_OFF_CLKCTL, cv[k]);
			wr(`DHM_OFF_SYSCTL, 8'h80);
			wt(6);
			want_pin <= 1'b1;
			wfor(1'b1, 1'b0);
			chb(wu_src_low_q, ev[k]);
			chb(lf_osc_en_q, cv[k][3]);
			wfor(1'b0, 1'b1);
			want_pin <= 1'b0;
		end
		wr(`DHM_OFF_CLKCTL, 8'h04);
		// Key wakeup at high level
		wr(`DHM_OFF_KEY, 8'h03);
		wr(`DHM_OFF_SYSCTL, 8'h80);
		wt(6);
		want_key <= 1'b1;
		wfor(1'b1, 1'b0);
		wfor(1'b0, 1'b1);
		want_key <= 1'b0;
		wr(`DHM_OFF_KEY, 8'h00);
		// Voltage detect and reset pin end halt
		wr(`DHM_OFF_SYSCTL, 8'h80);
		wt(6);
		vdet_low <= 1'b1;
		wt(6);
		chb(halted_q | core_run_q, 1'b0);
		vdet_low <= 1'b0;
		wfor(1'b0, 1'b1);
		rdc(`DHM_OFF_WUSET, 8'h10);
		wr(`DHM_OFF_SYSCTL, 8'h80);
		wt(6);
		rst_n <= 1'b0;
		wt(3);
		chb(halted_q, 1'b0);
		rst_n <= 1'b1;
		wfor(1'b0, 1'b1);
		rdc(`DHM_OFF_SYSCTL, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
